// file: logic/lad_alarm_detect.sv
/*
  lad_alarm_detect: receive line alarm detector for one T1/J1 channel,
  with its host registers, change flags and interrupt output.
  assumes: all line strobes and the in-sync level come from framer logic
  on mclk; the host port never holds write and read strobes together.
*/
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
// Notes on behaviour
// - blue alarm sets after N windows each with fewer than 61 zeros.
// - blue alarm clears after M windows each with more than 60 zeros.
// - remote alarm is judged only over windows spent wholly in sync.
// - T1 SF or SLC-96: fewer than 77 bit-2 ones declares remote.
// - T1 SF or SLC-96: more than 76 bit-2 ones clears remote.
// - T1 ESF: more than 7 sliding 0xFF00 patterns declares remote.
// - T1 ESF: fewer than 8 sliding 0xFF00 patterns clears remote.
// - T1 DM: fewer than 4 ones on the Y bit declares remote.
// - T1 DM: more than 3 ones on the Y bit clears remote.
// - J1 SF: fewer than 4 zeros on frame-12 F bit declares remote.
// - J1 SF: more than 3 zeros on frame-12 F bit clears remote.
// - J1 ESF: fewer than 3 data link zeros declares remote.
// - J1 ESF: more than 2 data link zeros clears remote.
// - sync loss declares after N whole windows out of frame.
// - sync loss clears after M times 120 ms in frame.
// - each change flag sets on any toggle of its alarm state.
// - change flags stay set until software writes one to them.
// - interrupt low while any flag is set with its enable high.
// - each alarm has its own 8-bit declare and clear counts.
module lad_alarm_detect
   import lad_pkg::*;
#(
   parameter int unsigned WIN_CYC = LAD_WINDOW_CYC
)(
   input  wire logic       mclk,
   input  wire logic       arst_n,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWdata,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output logic [7:0]      regRdata,
   input  wire logic       inSync,
   input  wire logic       rxBitValid,
   input  wire logic       rxBit,
   input  wire logic       chanBit2Valid,
   input  wire logic       chanBit2,
   input  wire logic       yBitValid,
   input  wire logic       yBit,
   input  wire logic       fBit12Valid,
   input  wire logic       fBit12,
   input  wire logic       dataLinkBitsValid,
   input  wire logic       dataLinkBits,
   output logic            alarmIrqN
);

   function automatic logic regHit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   // returns {declare, clear} for the remote alarm in the given format
   function automatic logic [1:0] remoteJudge(input lad_mode_t m, input logic [7:0] c);
      logic [1:0] v;
      v = 2'b00;
      case (m)
         LAD_T1_ESF: begin
            v = {c > LAD_ESF_DECL_GT, c < LAD_ESF_CLR_LT};
         end
         LAD_T1_DM: begin
            v = {c < LAD_DM_DECL_LT, c > LAD_DM_CLR_GT};
         end
         LAD_J1_SF: begin
            v = {c < LAD_J1SF_DECL_LT, c > LAD_J1SF_CLR_GT};
         end
         LAD_J1_ESF: begin
            v = {c < LAD_J1ESF_DECL_LT, c > LAD_J1ESF_CLR_GT};
         end
         default: begin
            v = {c < LAD_SF_DECL_LT, c > LAD_SF_CLR_GT};
         end
      endcase
      return v;
   endfunction

   // host registers
   logic [2:0]  irqEn_r;
   logic [2:0]  flags_r;
   logic [2:0]  flags_nxt;
   logic [7:0]  syncDeclN_r;
   logic [7:0]  syncClrM_r;
   logic [7:0]  remDeclN_r;
   logic [7:0]  remClrM_r;
   logic [7:0]  blueDeclN_r;
   logic [7:0]  blueClrM_r;
   lad_mode_t   mode_r;
   logic [7:0]  rdata_r;
   logic [7:0]  rdMux;

   // window timing and line observation
   logic [18:0] winCnt_r;
   logic        winEnd;
   logic        winDone_r;
   logic        syncWhole_r;
   logic        oosWhole_r;
   logic        syncSnap_r;
   logic        oosSnap_r;
   logic [15:0] dlShift_r;
   logic [15:0] dlShift_nxt;
   logic        patMatch;
   logic        blueEvent;
   logic        remEvent;
   logic [7:0]  blueCount;
   logic [7:0]  remCount;
   logic [1:0]  remVerdict;

   // alarm states and toggles
   logic [2:0]  alarmVec;
   logic [2:0]  alarmPrev_r;
   logic [2:0]  alarmChg;
   logic        wrFlags;

   lad_persist_if pif [3] ();

   assign winEnd = (winCnt_r == 19'(WIN_CYC - 1));

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         winCnt_r  <= 19'h0_0000;
         winDone_r <= 1'b0;
      end else begin
         winCnt_r  <= winEnd ? 19'h0_0000 : winCnt_r + 19'h0_0001;
         winDone_r <= winEnd;
      end
   end

   // whole-window sync tracking; a window that saw both states decides nothing
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         syncWhole_r <= 1'b1;
         oosWhole_r  <= 1'b1;
         syncSnap_r  <= 1'b0;
         oosSnap_r   <= 1'b0;
      end else if (winEnd) begin
         syncSnap_r  <= syncWhole_r && inSync;
         oosSnap_r   <= oosWhole_r && !inSync;
         syncWhole_r <= 1'b1;
         oosWhole_r  <= 1'b1;
      end else begin
         syncWhole_r <= syncWhole_r && inSync;
         oosWhole_r  <= oosWhole_r && !inSync;
      end
   end

   // sliding data link pattern, first received bit lands in the top bit
   assign dlShift_nxt = {dlShift_r[14:0], dataLinkBits};
   assign patMatch    = dataLinkBitsValid && (dlShift_nxt == LAD_ESF_PATTERN);

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         dlShift_r <= 16'h0000;
      end else if (dataLinkBitsValid) begin
         dlShift_r <= dlShift_nxt;
      end
   end

   assign blueEvent = rxBitValid && !rxBit;

   // remote events only count while in frame
   always_comb begin
      remEvent = 1'b0;
      case (mode_r)
         LAD_T1_ESF: remEvent = patMatch;
         LAD_T1_DM:  remEvent = yBitValid && yBit;
         LAD_J1_SF:  remEvent = fBit12Valid && !fBit12;
         LAD_J1_ESF: remEvent = dataLinkBitsValid && !dataLinkBits;
         default:    remEvent = chanBit2Valid && chanBit2;
      endcase
      remEvent = remEvent && inSync;
   end

   lad_win_count u_blue_count (
      .mclk      (mclk),
      .arst_n    (arst_n),
      .winEnd    (winEnd),
      .event_i   (blueEvent),
      .lastCount (blueCount),
      .done      ()
   );

   lad_win_count u_rem_count (
      .mclk      (mclk),
      .arst_n    (arst_n),
      .winEnd    (winEnd),
      .event_i   (remEvent),
      .lastCount (remCount),
      .done      ()
   );

   assign remVerdict = remoteJudge(mode_r, remCount);

   assign pif[LAD_BIT_BLUE].winEnd  = winDone_r;
   assign pif[LAD_BIT_BLUE].declare = blueCount < LAD_BLUE_DECL_LT;
   assign pif[LAD_BIT_BLUE].clear   = blueCount > LAD_BLUE_CLR_GT;
   assign pif[LAD_BIT_BLUE].needN   = {2'b00, blueDeclN_r};
   assign pif[LAD_BIT_BLUE].needM   = {2'b00, blueClrM_r};

   // out-of-frame windows are skipped, not failed, so the count holds
   assign pif[LAD_BIT_REMOTE].winEnd  = winDone_r && syncSnap_r;
   assign pif[LAD_BIT_REMOTE].declare = remVerdict[1];
   assign pif[LAD_BIT_REMOTE].clear   = remVerdict[0];
   assign pif[LAD_BIT_REMOTE].needN   = {2'b00, remDeclN_r};
   assign pif[LAD_BIT_REMOTE].needM   = {2'b00, remClrM_r};

   assign pif[LAD_BIT_SYNC].winEnd  = winDone_r;
   assign pif[LAD_BIT_SYNC].declare = oosSnap_r;
   assign pif[LAD_BIT_SYNC].clear   = syncSnap_r;
   assign pif[LAD_BIT_SYNC].needN   = {2'b00, syncDeclN_r};
   assign pif[LAD_BIT_SYNC].needM   = 10'(syncClrM_r * LAD_SYNC_CLR_WIN);

   for (genvar g = 0; g < 3; g++) begin : g_alarm
      lad_persist u_persist (
         .mclk   (mclk),
         .arst_n (arst_n),
         .pif    (pif[g])
      );
      assign alarmVec[g] = pif[g].alarm;
   end

   // change flags: a toggle in the clearing cycle wins over the clear
   assign alarmChg  = alarmVec ^ alarmPrev_r;
   assign wrFlags   = regWr && regHit(regAddr, LAD_OFF_FLAGS);
   assign flags_nxt = (flags_r & ~(wrFlags ? regWdata[2:0] : 3'h0)) | alarmChg;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         alarmPrev_r <= 3'h0;
         flags_r     <= LAD_RST_FLAGS;
      end else begin
         alarmPrev_r <= alarmVec;
         flags_r     <= flags_nxt;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         irqEn_r     <= LAD_RST_IRQ_EN;
         syncDeclN_r <= LAD_RST_SYNC_DECL;
         syncClrM_r  <= LAD_RST_SYNC_CLR;
         remDeclN_r  <= LAD_RST_REM_DECL;
         remClrM_r   <= LAD_RST_REM_CLR;
         blueDeclN_r <= LAD_RST_BLUE_DECL;
         blueClrM_r  <= LAD_RST_BLUE_CLR;
         mode_r      <= LAD_T1_SF;
      end else if (regWr) begin
         case (regAddr)
            LAD_OFF_IRQ_EN:    irqEn_r     <= regWdata[2:0];
            LAD_OFF_SYNC_DECL: syncDeclN_r <= regWdata;
            LAD_OFF_SYNC_CLR:  syncClrM_r  <= regWdata;
            LAD_OFF_REM_DECL:  remDeclN_r  <= regWdata;
            LAD_OFF_REM_CLR:   remClrM_r   <= regWdata;
            LAD_OFF_BLUE_DECL: blueDeclN_r <= regWdata;
            LAD_OFF_BLUE_CLR:  blueClrM_r  <= regWdata;
            LAD_OFF_MODE:      mode_r      <= lad_mode_t'(regWdata[2:0]);
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      case (regAddr)
         LAD_OFF_STATE:     rdMux = {5'h00, alarmVec};
         LAD_OFF_IRQ_EN:    rdMux = {5'h00, irqEn_r};
         LAD_OFF_FLAGS:     rdMux = {5'h00, flags_r};
         LAD_OFF_SYNC_DECL: rdMux = syncDeclN_r;
         LAD_OFF_SYNC_CLR:  rdMux = syncClrM_r;
         LAD_OFF_REM_DECL:  rdMux = remDeclN_r;
         LAD_OFF_REM_CLR:   rdMux = remClrM_r;
         LAD_OFF_BLUE_DECL: rdMux = blueDeclN_r;
         LAD_OFF_BLUE_CLR:  rdMux = blueClrM_r;
         LAD_OFF_MODE:      rdMux = {5'h00, mode_r};
         default:           rdMux = 8'h00;
      endcase
   end

   // read data stands for exactly one cycle, zero otherwise
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= regRd ? rdMux : 8'h00;
      end
   end

   assign regRdata  = rdata_r;
   assign alarmIrqN = ~|(flags_r & irqEn_r);

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);

   AST_CHG_SET: assert property (alarmVec[LAD_BIT_BLUE] != alarmPrev_r[LAD_BIT_BLUE]
      |=> flags_r[LAD_BIT_BLUE])
      else $error("blue toggle did not set its change flag");
   AST_FLAG_HOLD: assert property (flags_r[LAD_BIT_SYNC]
      && !(wrFlags && regWdata[LAD_BIT_SYNC]) |=> flags_r[LAD_BIT_SYNC])
      else $error("change flag dropped without a write of one");
   AST_FLAG_W1C: assert property (wrFlags && regWdata[LAD_BIT_REMOTE]
      && !alarmChg[LAD_BIT_REMOTE] |=> !flags_r[LAD_BIT_REMOTE])
      else $error("write of one did not clear change flag");
   AST_IRQ_ON: assert property ($rose(flags_r[LAD_BIT_BLUE]) && irqEn_r[LAD_BIT_BLUE]
      |-> !alarmIrqN)
      else $error("enabled change did not raise interrupt");
   AST_IRQ_MASK: assert property (irqEn_r == 3'h0 |-> alarmIrqN)
      else $error("interrupt raised with all enables off");
   AST_BLUE_DECL: assert property ($rose(alarmVec[LAD_BIT_BLUE])
      |-> $past(winDone_r) && $past(blueCount) < LAD_BLUE_DECL_LT)
      else $error("blue declared without a low zero count");
   AST_BLUE_CLR: assert property ($fell(alarmVec[LAD_BIT_BLUE])
      |-> $past(blueCount) > LAD_BLUE_CLR_GT)
      else $error("blue cleared without a high zero count");
   AST_REM_GATED: assert property (winDone_r && !syncSnap_r
      |=> $stable(alarmVec[LAD_BIT_REMOTE]))
      else $error("remote alarm moved after an unsynced window");
   AST_SYNC_DECL: assert property ($rose(alarmVec[LAD_BIT_SYNC]) |-> $past(oosSnap_r))
      else $error("sync loss declared after an in-frame window");
   AST_SYNC_CLR: assert property ($fell(alarmVec[LAD_BIT_SYNC]) |-> $past(syncSnap_r))
      else $error("sync loss cleared after an unsynced window");
   AST_RD_DATA: assert property (regRd && regAddr == LAD_OFF_STATE
      |=> regRdata == {5'h00, $past(alarmVec)})
      else $error("state read returned wrong data");
   AST_RD_IDLE: assert property (!regRd |=> regRdata == 8'h00)
      else $error("read data outside its cycle");

   COV_BLUE: cover property ($rose(alarmVec[LAD_BIT_BLUE]));
   COV_REMOTE: cover property ($rose(alarmVec[LAD_BIT_REMOTE]));
   COV_SYNC: cover property ($fell(alarmVec[LAD_BIT_SYNC]));
   COV_IRQ: cover property ($fell(alarmIrqN));

endmodule

// file: logic/lad_persist.sv
/*
  lad_persist: counts consecutive qualifying windows and flips one alarm.
  assumes: verdicts are valid only in the cycle winEnd is high.
*/
`timescale 1ns/100ps
module lad_persist
   import lad_pkg::*;
(
   input  wire logic   mclk,
   input  wire logic   arst_n,
   lad_persist_if.judge pif
);
   logic [9:0] cnt_r;
   logic [9:0] cntInc;
   logic       alarm_r;

   assign cntInc = cnt_r + 10'h001;

   // a threshold of zero acts like one: the first qualifying window decides
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r   <= 10'h000;
         alarm_r <= 1'b0;
      end else if (pif.winEnd) begin
         if (!alarm_r && pif.declare) begin
            if (cntInc >= pif.needN) begin
               alarm_r <= 1'b1;
               cnt_r   <= 10'h000;
            end else begin
               cnt_r <= cntInc;
            end
         end else if (alarm_r && pif.clear) begin
            if (cntInc >= pif.needM) begin
               alarm_r <= 1'b0;
               cnt_r   <= 10'h000;
            end else begin
               cnt_r <= cntInc;
            end
         end else begin
            cnt_r <= 10'h000;
         end
      end
   end

   assign pif.alarm = alarm_r;

   AST_RESTART: assert property (@(posedge mclk) disable iff (!arst_n)
      pif.winEnd && !alarm_r && !pif.declare |=> cnt_r == 10'h000)
      else $error("window count not restarted");
   AST_DECL_NEEDS_N: assert property (@(posedge mclk) disable iff (!arst_n)
      $rose(alarm_r) |-> $past(pif.winEnd) && $past(pif.declare) &&
                         ($past(cntInc) >= $past(pif.needN)))
      else $error("alarm declared without enough windows");
   AST_CLR_NEEDS_M: assert property (@(posedge mclk) disable iff (!arst_n)
      $fell(alarm_r) |-> $past(pif.winEnd) && $past(pif.clear) &&
                         ($past(cntInc) >= $past(pif.needM)))
      else $error("alarm cleared without enough windows");
endmodule

// file: logic/lad_persist_if.sv
/*
  lad_persist_if: one alarm's window verdicts, thresholds and state.
  assumes: driven by the detector core, read by one persistence judge.
*/
`timescale 1ns/100ps
interface lad_persist_if;
   logic       winEnd;
   logic       declare;
   logic       clear;
   logic [9:0] needN;
   logic [9:0] needM;
   logic       alarm;

   modport core  (output winEnd, output declare, output clear,
                  output needN, output needM, input alarm);
   modport judge (input winEnd, input declare, input clear,
                  input needN, input needM, output alarm);
endinterface

// file: logic/lad_pkg.sv
/*
  lad_pkg: register offsets, reset values, field positions, limits and
  timing constants of the receive line alarm detector.
  assumes: a 10 MHz framer clock and an 8-bit host register port.
*/
package lad_pkg;

   // register offsets
   localparam logic [7:0] LAD_OFF_STATE     = 8'hb9;
   localparam logic [7:0] LAD_OFF_IRQ_EN    = 8'hba;
   localparam logic [7:0] LAD_OFF_FLAGS     = 8'hbb;
   localparam logic [7:0] LAD_OFF_SYNC_DECL = 8'hbc;
   localparam logic [7:0] LAD_OFF_SYNC_CLR  = 8'hbd;
   localparam logic [7:0] LAD_OFF_REM_DECL  = 8'hbe;
   localparam logic [7:0] LAD_OFF_REM_CLR   = 8'hbf;
   localparam logic [7:0] LAD_OFF_BLUE_DECL = 8'hc0;
   localparam logic [7:0] LAD_OFF_BLUE_CLR  = 8'hc1;
   localparam logic [7:0] LAD_OFF_MODE      = 8'hc8;

   // reset values
   localparam logic [7:0] LAD_RST_SYNC_DECL = 8'h3f;
   localparam logic [7:0] LAD_RST_SYNC_CLR  = 8'h7f;
   localparam logic [7:0] LAD_RST_REM_DECL  = 8'h0a;
   localparam logic [7:0] LAD_RST_REM_CLR   = 8'h0a;
   localparam logic [7:0] LAD_RST_BLUE_DECL = 8'h3f;
   localparam logic [7:0] LAD_RST_BLUE_CLR  = 8'h3f;
   localparam logic [2:0] LAD_RST_IRQ_EN    = 3'h0;
   localparam logic [2:0] LAD_RST_FLAGS     = 3'h0;

   // field positions inside state, enable and change registers
   localparam int LAD_BIT_BLUE   = 2;
   localparam int LAD_BIT_REMOTE = 1;
   localparam int LAD_BIT_SYNC   = 0;

   // framing formats
   typedef enum logic [2:0] {
      LAD_T1_SF, LAD_SLC96, LAD_T1_ESF, LAD_T1_DM, LAD_J1_SF, LAD_J1_ESF
   } lad_mode_t;

   // window counts
   localparam logic [7:0]  LAD_BLUE_DECL_LT  = 8'h3d;
   localparam logic [7:0]  LAD_BLUE_CLR_GT   = 8'h3c;
   localparam logic [7:0]  LAD_SF_DECL_LT    = 8'h4d;
   localparam logic [7:0]  LAD_SF_CLR_GT     = 8'h4c;
   localparam logic [7:0]  LAD_ESF_DECL_GT   = 8'h07;
   localparam logic [7:0]  LAD_ESF_CLR_LT    = 8'h08;
   localparam logic [7:0]  LAD_DM_DECL_LT    = 8'h04;
   localparam logic [7:0]  LAD_DM_CLR_GT     = 8'h03;
   localparam logic [7:0]  LAD_J1SF_DECL_LT  = 8'h04;
   localparam logic [7:0]  LAD_J1SF_CLR_GT   = 8'h03;
   localparam logic [7:0]  LAD_J1ESF_DECL_LT = 8'h03;
   localparam logic [7:0]  LAD_J1ESF_CLR_GT  = 8'h02;
   localparam logic [15:0] LAD_ESF_PATTERN   = 16'hff00;
   localparam logic [7:0]  LAD_COUNT_MAX     = 8'hff;

   // timing
   localparam int unsigned LAD_CLK_HZ      = 10_000_000;
   localparam int unsigned LAD_WINDOW_MS   = 40;
   localparam int unsigned LAD_SYNC_CLR_MS = 120;
   localparam int unsigned LAD_WINDOW_CYC  = LAD_WINDOW_MS * (LAD_CLK_HZ / 1000);
   localparam int unsigned LAD_SYNC_CLR_WIN = LAD_SYNC_CLR_MS / LAD_WINDOW_MS;

endpackage

// file: logic/lad_win_count.sv
/*
  lad_win_count: saturating event counter over one fixed window.
  assumes: winEnd is a one-cycle pulse on the same clock as the events.
*/
`timescale 1ns/100ps
module lad_win_count
   import lad_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       arst_n,
   input  wire logic       winEnd,
   input  wire logic       event_i,
   output logic [7:0]      lastCount,
   output logic            done
);
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic [7:0] last_r;
   logic       done_r;

   // saturate so a busy line never wraps back below a limit
   always_comb begin
      cnt_nxt = cnt_r;
      if (event_i && cnt_r != LAD_COUNT_MAX) begin
         cnt_nxt = cnt_r + 8'h01;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r  <= 8'h00;
         last_r <= 8'h00;
         done_r <= 1'b0;
      end else if (winEnd) begin
         last_r <= cnt_nxt;
         cnt_r  <= 8'h00;
         done_r <= 1'b1;
      end else begin
         cnt_r  <= cnt_nxt;
         done_r <= 1'b0;
      end
   end

   assign lastCount = last_r;
   assign done      = done_r;
endmodule

// file: tb/lad_alarm_detect_tb.sv
/*
  lad_alarm_detect_tb: register, alarm and interrupt checks of the detector.
  assumes: a short window of 200 cycles; reads are checked from a queue.
*/
`timescale 1ns/100ps
module lad_alarm_detect_tb
   import lad_pkg::*;
;
   localparam int W = 200;
   logic       mclk, arst_n, regWr, regRd, inSync, alarmIrqN, rdSeen;
   logic       bitValid, rxBit, chanBit2, yBit, fBit12, dataLinkBits;
   logic       blueAlarm, remAlarm, dlPat;
   logic [7:0] regAddr, regWdata, regRdata;
   logic [31:0] lfsr;
   logic [7:0] expQ [$];
   int         n_errors, num_checks, cyc;
   logic [7:0] offs [10] = '{8'hb9, 8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hbf,
                             8'hc0, 8'hc1, 8'hc8};
   logic [7:0] rstv [10] = '{8'h00, 8'h00, 8'h00, 8'h3f, 8'h7f, 8'h0a, 8'h0a,
                             8'h3f, 8'h3f, 8'h00};

   lad_alarm_detect #(.WIN_CYC(W)) lad_alarm_detect_i (
      .mclk(mclk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .inSync(inSync),
      .rxBitValid(bitValid), .rxBit(rxBit), .chanBit2Valid(bitValid),
      .chanBit2(chanBit2), .yBitValid(bitValid), .yBit(yBit),
      .fBit12Valid(bitValid), .fBit12(fBit12), .dataLinkBitsValid(bitValid),
      .dataLinkBits(dataLinkBits), .alarmIrqN(alarmIrqN));

   lad_line_model lad_line_model_i (
      .mclk(mclk), .arst_n(arst_n), .blueAlarm(blueAlarm), .remAlarm(remAlarm),
      .dlPat(dlPat), .bitValid(bitValid), .rxBit(rxBit), .chanBit2(chanBit2),
      .yBit(yBit), .fBit12(fBit12), .dataLinkBits(dataLinkBits));

   initial mclk = 1'b0;
   always #50 mclk = ~mclk;

   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) cyc <= 0;
      else cyc <= cyc + 1;
   end

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      regWr <= 1'b1; regAddr <= a; regWdata <= d;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask

   // the note is queued; the monitor compares in the answer cycle
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      regRd <= 1'b1; regAddr <= a; expQ.push_back(e);
      @(posedge mclk);
      regRd <= 1'b0;
   endtask

   task automatic irq(input logic e);
      @(negedge mclk);
      chk({7'h00, alarmIrqN}, {7'h00, e});
   endtask

   // offsets stay clear of the window edge by a safe margin
   task automatic toOff(input int o);
      do @(posedge mclk); while (cyc % W != o);
   endtask

   always @(posedge mclk) rdSeen <= regRd;
   always @(negedge mclk) if (rdSeen === 1'b1) chk(regRdata, expQ.pop_front());

   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      repeat (60 * W) @(posedge mclk);
      n_errors++;
      $display("timeout at %0t", $time);
      test_done;
   end

   initial begin
      regWr = 0; regRd = 0; regAddr = 0; regWdata = 0; inSync = 1; rdSeen = 0;
      blueAlarm = 0; remAlarm = 0; dlPat = 0; arst_n = 0; lfsr = 32'hd886_ae99;
      n_errors = 0; num_checks = 0;
      repeat (3) @(posedge mclk);
      arst_n <= 1'b1;
      for (int i = 0; i < 10; i++) rd(offs[i], rstv[i]);
      rd(8'hc5, 8'h00);
      wr(LAD_OFF_STATE, 8'hff);
      rd(LAD_OFF_STATE, 8'h00);
      for (int i = 3; i < 9; i++) begin
         lfsr = nxt(lfsr);
         wr(offs[i], lfsr[7:0]);
         rd(offs[i], lfsr[7:0]);
      end
      wr(LAD_OFF_IRQ_EN, lfsr[15:8]);
      rd(LAD_OFF_IRQ_EN, {5'h00, lfsr[10:8]});
      for (int i = 3; i < 10; i++) wr(offs[i], (i == 7) ? 8'h02 : (i == 9) ? 8'h00 : 8'h01);
      wr(LAD_OFF_IRQ_EN, 8'h04);
      // a failing window, then two all-ones windows
      toOff(150);
      blueAlarm <= 1'b1;
      toOff(10);
      toOff(10);
      rd(LAD_OFF_STATE, 8'h00);
      toOff(10);
      rd(LAD_OFF_STATE, 8'h04);
      rd(LAD_OFF_FLAGS, 8'h04);
      irq(1'b0);
      wr(LAD_OFF_IRQ_EN, 8'h00);
      irq(1'b1);
      rd(LAD_OFF_FLAGS, 8'h04);
      wr(LAD_OFF_FLAGS, 8'h04);
      rd(LAD_OFF_FLAGS, 8'h00);
      wr(LAD_OFF_IRQ_EN, 8'h04);
      irq(1'b1);
      blueAlarm <= 1'b0;
      toOff(10);
      rd(LAD_OFF_STATE, 8'h00);
      rd(LAD_OFF_FLAGS, 8'h04);
      irq(1'b0);
      wr(LAD_OFF_FLAGS, 8'h04);
      for (int m = 0; m < 6; m++) begin
         wr(LAD_OFF_MODE, m[7:0]);
         remAlarm <= 1'b1;
         dlPat    <= (m == 2);
         toOff(10);
         toOff(10);
         rd(LAD_OFF_STATE, 8'h02);
         remAlarm <= 1'b0;
         dlPat    <= (m == 5);
         toOff(10);
         toOff(10);
         rd(LAD_OFF_STATE, 8'h00);
         rd(LAD_OFF_FLAGS, 8'h02);
         wr(LAD_OFF_FLAGS, 8'h02);
      end
      wr(LAD_OFF_MODE, 8'h00);
      toOff(10);
      inSync   <= 1'b0;
      remAlarm <= 1'b1;
      toOff(10);
      toOff(10);
      rd(LAD_OFF_STATE, 8'h01);
      inSync   <= 1'b1;
      remAlarm <= 1'b0;
      toOff(10);
      toOff(10);
      toOff(10);
      rd(LAD_OFF_STATE, 8'h01);
      toOff(10);
      rd(LAD_OFF_STATE, 8'h00);
      rd(LAD_OFF_FLAGS, 8'h01);
      repeat (2) @(posedge mclk);
      test_done;
   end
endmodule

// file: tb/lad_line_model.sv
/*
  lad_line_model: far-end line seen through the framer, one strobe per cycle.
  assumes: the bench picks alarm or clean patterns; the framer spreads bits.
*/
`timescale 1ns/100ps
module lad_line_model (
   input  wire logic mclk,
   input  wire logic arst_n,
   input  wire logic blueAlarm,
   input  wire logic remAlarm,
   input  wire logic dlPat,
   output logic      bitValid,
   output logic      rxBit,
   output logic      chanBit2,
   output logic      yBit,
   output logic      fBit12,
   output logic      dataLinkBits
);
   logic [3:0] phase_r;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         phase_r  <= 4'h0;
         bitValid <= 1'b0;
      end else begin
         phase_r  <= phase_r + 4'h1;
         bitValid <= 1'b1;
      end
   end

   // all ones hides every zero
   assign rxBit        = blueAlarm;
   assign chanBit2     = ~remAlarm;
   assign yBit         = ~remAlarm;
   assign fBit12       = remAlarm;
   // eight ones then eight zeros gives one match every 16 bits
   assign dataLinkBits = dlPat ? ~phase_r[3] : 1'b1;
endmodule
